// [temp_channel_eval.sv]
/*
  Module: one channel's fault substitution, window comparison and hardware
  limit with hysteresis. Assumes inputs from the same clock domain.
*/
`timescale 1ns/1ps
module temp_channel_eval
  import temp_readout_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // conversion in
  input wire logic convDone,
  input wire logic [TEMP_W-1:0] rawTemp,
  input wire diode_state_t diodeState,
  // limits
  input wire logic [TEMP_W-1:0] highLim,
  input wire logic [TEMP_W-1:0] lowLim,
  input wire logic [TEMP_W-1:0] hwLim,
  input wire logic [TEMP_W-1:0] hyst,
  // results
  output logic [TEMP_W-1:0] result,
  output logic highEvt,
  output logic lowEvt,
  output logic openEvt,
  output logic hwOver
);
  logic [TEMP_W-1:0] result_r;
  logic hwOver_r;
  logic highEvt_r;
  logic lowEvt_r;
  logic openEvt_r;
  wire logic [TEMP_W-1:0] subst;
  wire logic signed [TEMP_W:0] hwRelease;
  wire logic isHigh;
  wire logic isLow;
  wire logic hwTrip;
  wire logic hwClear;

  assign subst = (diodeState == DIODE_OPEN) ? TEMP_OPEN_FAULT :
                 (diodeState == DIODE_SHORT) ? TEMP_SHORT_FAULT : rawTemp;
  assign isHigh = $signed(subst) > $signed(highLim);
  assign isLow = $signed(subst) <= $signed(lowLim);
  assign hwTrip = $signed(subst) > $signed(hwLim);
  assign hwRelease = $signed({hwLim[TEMP_W-1], hwLim}) - $signed({1'b0, hyst});
  assign hwClear = $signed({subst[TEMP_W-1], subst}) <= hwRelease;

  always_ff @(posedge clk) begin
    if (rst) begin
      result_r <= RST_ZERO;
      hwOver_r <= 1'b0;
      highEvt_r <= 1'b0;
      lowEvt_r <= 1'b0;
      openEvt_r <= 1'b0;
    end else begin
      highEvt_r <= convDone & isHigh;
      lowEvt_r <= convDone & isLow;
      openEvt_r <= convDone & (diodeState == DIODE_OPEN);
      if (convDone) begin
        result_r <= subst;
        if (hwTrip) begin
          hwOver_r <= 1'b1;
        end else if (hwClear) begin
          hwOver_r <= 1'b0;
        end
      end
    end
  end

  assign result = result_r;
  assign highEvt = highEvt_r;
  assign lowEvt = lowEvt_r;
  assign openEvt = openEvt_r;
  assign hwOver = hwOver_r;
endmodule // temp_channel_eval

// [temp_readout.sv]
/*
  Module: temperature readout, diode fault check, limit registers,
  interrupt status and fan converter control behind an APB slave.
  Assumes raw readings and diode pin levels from the analog front end;
  pins cross three flip-flops, converter data come from the sequencer clock.
*/
`timescale 1ns/1ps
// What this block does
// - readings and limits signed, one degree
// - host writes limits and control registers, not results; reads all but the interrupt clear register, which reads zero
// - compare against limits, hardware limit with hysteresis
// - internal plus two remote channels
// - fault check before each remote report
// - open or supply short reads 127, flags
// - ground or cathode short reads zero
// - eight bit converter code
// - converter resets to full scale
// - overdriven converter pin enters test mode
// - first bus transaction leaves test mode
// - status read clears returned flags
// - alarm line forces full scale temporarily
module temp_readout
  import temp_readout_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // conversion sequencer
  input wire logic convStart,
  input wire logic [NUM_CH-1:0] convValid,
  input wire logic [TEMP_W-1:0] rawInt,
  input wire logic [TEMP_W-1:0] rawD1,
  input wire logic [TEMP_W-1:0] rawD2,
  // remote diode comparator pins: anode high, anode low
  input wire logic [1:0] diodeHiPin,
  input wire logic [1:0] diodeLoPin,
  // test and bus activity pins
  input wire logic dacOverdrivePin,
  input wire logic serialBusStart,
  // overtemp alarm line, open drain
  input wire logic overtempAlarmLineIn,
  output logic overtempAlarmLineOut,
  output logic overtempAlarmLineOe,
  // converter and mode outputs
  output logic [DAC_W-1:0] dacCode,
  output logic testMode,
  output logic irq
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  localparam int NPIN = 7;
  logic [NPIN-1:0] pinS1_r;
  logic [NPIN-1:0] pinS2_r;
  logic [NPIN-1:0] pinS3_r;
  logic [NPIN-1:0] pinStable_r;
  wire logic [NPIN-1:0] pinRaw;
  assign pinRaw = {serialBusStart, dacOverdrivePin, overtempAlarmLineIn,
                   diodeLoPin, diodeHiPin};

  // a change counts only once stages two and three agree
  always_ff @(posedge clk) begin
    pinS1_r <= pinRaw;
    pinS2_r <= pinS1_r;
    pinS3_r <= pinS2_r;
  end

  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp++) begin : g_pin
      always_ff @(posedge clk) begin
        if (rst) begin
          pinStable_r[gp] <= (gp == 4) ? 1'b1 : 1'b0;
        end else if (pinS2_r[gp] == pinS3_r[gp]) begin
          pinStable_r[gp] <= pinS3_r[gp];
        end
      end
    end
  endgenerate

  wire logic [1:0] dHi;
  wire logic [1:0] dLo;
  wire logic alarmIn;
  wire logic overdrive;
  wire logic busStart;
  assign dHi = pinStable_r[1:0];
  assign dLo = pinStable_r[3:2];
  assign alarmIn = pinStable_r[4];
  assign overdrive = pinStable_r[5];
  assign busStart = pinStable_r[6];

  // ------------------------------------------------------------
  // remote fault sequence
  // ------------------------------------------------------------
  seq_state_t seq_r;
  seq_state_t seq_nxt;
  diode_state_t dState_r [2];
  logic [1:0] pendValid_r;

  function automatic diode_state_t classify(input logic hi, input logic lo);
    // anode stuck high: supply short or open; anode stuck low: short
    classify = hi ? DIODE_OPEN : (lo ? DIODE_SHORT : DIODE_OK);
  endfunction

  always_comb begin
    seq_nxt = seq_r;
    case (seq_r)
      SEQ_IDLE: begin
        if (convStart) begin
          seq_nxt = SEQ_CHECK;
        end
      end
      SEQ_CHECK: begin
        seq_nxt = SEQ_REPORT;
      end
      SEQ_REPORT: begin
        if (convStart) begin
          seq_nxt = SEQ_CHECK;
        end
      end
      default: begin
        seq_nxt = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      seq_r <= SEQ_IDLE;
      dState_r[0] <= DIODE_OK;
      dState_r[1] <= DIODE_OK;
      pendValid_r <= 2'b00;
    end else begin
      seq_r <= seq_nxt;
      if (seq_r == SEQ_CHECK) begin
        dState_r[0] <= classify(dHi[0], dLo[0]);
        dState_r[1] <= classify(dHi[1], dLo[1]);
      end
      // remote results wait for a completed fault check
      pendValid_r <= (seq_r == SEQ_REPORT) ? 2'b00 : (pendValid_r | convValid[2:1]);
    end
  end

  wire logic [NUM_CH-1:0] chDone;
  assign chDone = {seq_r == SEQ_REPORT && (pendValid_r[1] | convValid[2]),
                   seq_r == SEQ_REPORT && (pendValid_r[0] | convValid[1]),
                   convValid[0]};

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [TEMP_W-1:0] highInt_r, highExt_r, lowInt_r, lowExt_r;
  logic [TEMP_W-1:0] hwInt_r, hwExt_r, hyst_r;
  logic [DAC_W-1:0] dacSet_r;
  logic [7:0] status_r;
  logic [7:0] irqEn_r;
  logic modeOtOut_r;

  wire logic setup;
  wire logic access;
  wire logic wrAcc;
  wire logic rdAcc;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wrAcc = access & pwrite;
  assign rdAcc = access & ~pwrite;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  wire logic known;
  wire logic readOnly;
  assign known = hit(paddr, ADDR_TEMP_INT) | hit(paddr, ADDR_TEMP_D1) |
                 hit(paddr, ADDR_TEMP_D2) | hit(paddr, ADDR_HIGH_INT) |
                 hit(paddr, ADDR_HIGH_EXT) | hit(paddr, ADDR_LOW_INT) |
                 hit(paddr, ADDR_LOW_EXT) | hit(paddr, ADDR_HW_INT) |
                 hit(paddr, ADDR_HW_EXT) | hit(paddr, ADDR_HYST) |
                 hit(paddr, ADDR_DAC) | hit(paddr, ADDR_STATUS2) |
                 hit(paddr, ADDR_IRQ_EN) | hit(paddr, ADDR_IRQ_CLR) |
                 hit(paddr, ADDR_MODE);
  assign readOnly = hit(paddr, ADDR_TEMP_INT) | hit(paddr, ADDR_TEMP_D1) |
                    hit(paddr, ADDR_TEMP_D2) | hit(paddr, ADDR_STATUS2);

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  wire logic [TEMP_W-1:0] res [NUM_CH];
  wire logic [NUM_CH-1:0] hiEvt, loEvt, opEvt, hwOv;
  wire logic [TEMP_W-1:0] rawArr [NUM_CH];
  assign rawArr[0] = rawInt;
  assign rawArr[1] = rawD1;
  assign rawArr[2] = rawD2;

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
      temp_channel_eval u_eval (
        .clk(clk),
        .rst(rst),
        .convDone(chDone[gc]),
        .rawTemp(rawArr[gc]),
        .diodeState((gc == 0) ? DIODE_OK : dState_r[(gc == 0) ? 0 : gc - 1]),
        .highLim((gc == 0) ? highInt_r : highExt_r),
        .lowLim((gc == 0) ? lowInt_r : lowExt_r),
        .hwLim((gc == 0) ? hwInt_r : hwExt_r),
        .hyst(hyst_r),
        .result(res[gc]),
        .highEvt(hiEvt[gc]),
        .lowEvt(loEvt[gc]),
        .openEvt(opEvt[gc]),
        .hwOver(hwOv[gc])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // status and interrupt
  // ------------------------------------------------------------
  wire logic [7:0] events;
  wire logic statusRd;
  wire logic [7:0] clrMask;
  assign events = {opEvt[2], opEvt[1], loEvt, hiEvt};
  assign statusRd = rdAcc & hit(paddr, ADDR_STATUS2);
  assign clrMask = (statusRd ? prdata[7:0] : 8'h00) |
                   ((wrAcc & hit(paddr, ADDR_IRQ_CLR)) ? pwdata[7:0] : 8'h00);

  always_ff @(posedge clk) begin
    if (rst) begin
      status_r <= 8'h00;
      irq <= 1'b0;
    end else begin
      // event flags set; set beats clear
      status_r <= (status_r & ~clrMask) | events;
      irq <= |(((status_r & ~clrMask) | events) & irqEn_r);
    end
  end

  // ------------------------------------------------------------
  // writes, test mode, outputs
  // ------------------------------------------------------------
  wire logic [7:0] wb;
  assign wb = pwdata[7:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      highInt_r <= RST_HIGH;
      highExt_r <= RST_HIGH;
      lowInt_r <= RST_LOW;
      lowExt_r <= RST_LOW;
      hwInt_r <= RST_HIGH;
      hwExt_r <= RST_HIGH;
      hyst_r <= RST_HYST;
      dacSet_r <= DAC_FULL_SCALE;
      irqEn_r <= 8'h00;
      modeOtOut_r <= 1'b0;
    end else if (wrAcc) begin
      if (hit(paddr, ADDR_HIGH_INT)) begin
        highInt_r <= wb;
      end else if (hit(paddr, ADDR_HIGH_EXT)) begin
        highExt_r <= wb;
      end else if (hit(paddr, ADDR_LOW_INT)) begin
        lowInt_r <= wb;
      end else if (hit(paddr, ADDR_LOW_EXT)) begin
        lowExt_r <= wb;
      end else if (hit(paddr, ADDR_HW_INT)) begin
        hwInt_r <= wb;
      end else if (hit(paddr, ADDR_HW_EXT)) begin
        hwExt_r <= wb;
      end else if (hit(paddr, ADDR_HYST)) begin
        hyst_r <= wb;
      end else if (hit(paddr, ADDR_DAC)) begin
        dacSet_r <= wb;
      end else if (hit(paddr, ADDR_IRQ_EN)) begin
        irqEn_r <= wb;
      end else if (hit(paddr, ADDR_MODE)) begin
        modeOtOut_r <= wb[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      testMode <= 1'b0;
    end else if (busStart | access) begin
      testMode <= 1'b0;
    end else if (overdrive) begin
      testMode <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dacCode <= DAC_FULL_SCALE;
      overtempAlarmLineOut <= 1'b0;
      overtempAlarmLineOe <= 1'b0;
    end else begin
      dacCode <= alarmIn ? dacSet_r : DAC_FULL_SCALE;
      overtempAlarmLineOut <= 1'b0;
      // hardware limit or mode bit pulls the line low; test mode leaves the alarm line released
      overtempAlarmLineOe <= ~testMode & (modeOtOut_r | (|hwOv));
    end
  end

  // ------------------------------------------------------------
  // apb read
  // ------------------------------------------------------------
  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    if (hit(paddr, ADDR_TEMP_INT)) begin
      rdByte = res[0];
    end else if (hit(paddr, ADDR_TEMP_D1)) begin
      rdByte = res[1];
    end else if (hit(paddr, ADDR_TEMP_D2)) begin
      rdByte = res[2];
    end else if (hit(paddr, ADDR_HIGH_INT)) begin
      rdByte = highInt_r;
    end else if (hit(paddr, ADDR_HIGH_EXT)) begin
      rdByte = highExt_r;
    end else if (hit(paddr, ADDR_LOW_INT)) begin
      rdByte = lowInt_r;
    end else if (hit(paddr, ADDR_LOW_EXT)) begin
      rdByte = lowExt_r;
    end else if (hit(paddr, ADDR_HW_INT)) begin
      rdByte = hwInt_r;
    end else if (hit(paddr, ADDR_HW_EXT)) begin
      rdByte = hwExt_r;
    end else if (hit(paddr, ADDR_HYST)) begin
      rdByte = hyst_r;
    end else if (hit(paddr, ADDR_DAC)) begin
      rdByte = dacSet_r;
    end else if (hit(paddr, ADDR_STATUS2)) begin
      rdByte = status_r;
    end else if (hit(paddr, ADDR_IRQ_EN)) begin
      rdByte = irqEn_r;
    end else if (hit(paddr, ADDR_MODE)) begin
      rdByte = {7'h00, modeOtOut_r};
    end
  end

  // no wait state: ready is registered from the setup cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= APB_ZERO;
    end else begin
      pready <= setup;
      pslverr <= setup & (~known | (pwrite & readOnly));
      prdata <= (setup & ~pwrite) ? {24'h00_0000, rdByte} : APB_ZERO;
    end
  end
endmodule // temp_readout

// [temp_readout_assertions.sv]
/*
  Checker for temp_readout: bus timing, reset state, converter override.
  Assumes it is bound to the block's own ports.
*/
`timescale 1ns/1ps
module temp_readout_assertions
  import temp_readout_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic overtempAlarmLineIn,
  input wire logic [DAC_W-1:0] dacCode,
  input wire logic testMode,
  input wire logic irq
);
  logic [2:0] hiCnt_r;
  logic [7:0] wrData_r;
  logic dacWr;
  assign dacWr = psel && penable && pready && pwrite && paddr == ADDR_DAC;
  // released-line run length; the pin synchroniser needs a few edges
  always_ff @(posedge clk) begin
    if (rst || !overtempAlarmLineIn) begin
      hiCnt_r <= 3'h0;
    end else if (hiCnt_r != 3'h7) begin
      hiCnt_r <= hiCnt_r + 3'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (dacWr) begin
      wrData_r <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_PREADY_CAUSE: assert property (pready |-> penable && $past(psel && !penable))
    else $error("ready without a setup cycle");
  AST_PREADY_ONE: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single cycle after setup");
  AST_IDLE_ZERO: assert property (!pready |-> prdata == APB_ZERO && !pslverr)
    else $error("read data or error outside access");
  AST_RO_WRITE: assert property (psel && !penable && pwrite && paddr <= ADDR_TEMP_D2 |=> pslverr)
    else $error("result write not refused");
  AST_UNMAPPED: assert property (psel && !penable && paddr > ADDR_MODE |=> pslverr && prdata == APB_ZERO)
    else $error("unmapped access not refused");
  AST_RESET_STATE: assert property ($fell(rst) |-> dacCode == DAC_FULL_SCALE && !testMode && !irq)
    else $error("wrong state after reset");
  AST_ALARM_FULL: assert property ((!overtempAlarmLineIn) [*5] |=> dacCode == DAC_FULL_SCALE)
    else $error("alarm line did not force full scale");
  AST_DAC_WRITE: assert property (dacWr && hiCnt_r == 3'h7 |-> ##[1:2] dacCode == wrData_r)
    else $error("converter code not applied");
  AST_TEST_EXIT: assert property (testMode && psel && !penable |-> ##[1:2] !testMode)
    else $error("bus access did not leave test mode");
endmodule // temp_readout_assertions

bind temp_readout temp_readout_assertions i_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .overtempAlarmLineIn, .dacCode, .testMode, .irq);

// [temp_readout_pkg.sv]
/*
  Package: constants, register map and enumerations for the temperature
  readout and fan converter block. Assumes an APB slave with 32-bit data.
*/
package temp_readout_pkg;
  localparam int TEMP_W = 8;
  localparam int DAC_W = 8;
  localparam int NUM_CH = 3;
  // readings forced by the diode fault sequence
  localparam logic [7:0] TEMP_OPEN_FAULT = 8'h7F;
  localparam logic [7:0] TEMP_SHORT_FAULT = 8'h00;
  localparam logic [7:0] DAC_FULL_SCALE = 8'hFF;
  // fault flag positions in the second status register
  localparam int FAULT_BIT_D1 = 6;
  localparam int FAULT_BIT_D2 = 7;
  // register byte addresses
  localparam logic [7:0] ADDR_TEMP_INT = 8'h00;
  localparam logic [7:0] ADDR_TEMP_D1 = 8'h04;
  localparam logic [7:0] ADDR_TEMP_D2 = 8'h08;
  localparam logic [7:0] ADDR_HIGH_INT = 8'h0C;
  localparam logic [7:0] ADDR_HIGH_EXT = 8'h10;
  localparam logic [7:0] ADDR_LOW_INT = 8'h14;
  localparam logic [7:0] ADDR_LOW_EXT = 8'h18;
  localparam logic [7:0] ADDR_HW_INT = 8'h1C;
  localparam logic [7:0] ADDR_HW_EXT = 8'h20;
  localparam logic [7:0] ADDR_HYST = 8'h24;
  localparam logic [7:0] ADDR_DAC = 8'h28;
  localparam logic [7:0] ADDR_STATUS2 = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h30;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h34;
  localparam logic [7:0] ADDR_MODE = 8'h38;
  // reset values
  localparam logic [7:0] RST_HIGH = 8'h7F;
  localparam logic [7:0] RST_LOW = 8'h80;
  localparam logic [7:0] RST_HYST = 8'h02;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // status layout: [0..2] high per channel, [3..5] low per channel,
  // [6] d1 fault, [7] d2 fault
  localparam int ST_HIGH0 = 0;
  localparam int ST_LOW0 = 3;
  localparam int HW_W = 3;
  localparam logic [31:0] APB_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    DIODE_OK = 2'b00,
    DIODE_OPEN = 2'b01,
    DIODE_SHORT = 2'b10
  } diode_state_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CHECK = 2'b01,
    SEQ_REPORT = 2'b10
  } seq_state_t;
endpackage

// [temp_sensor_model.sv]
/*
  Model of the remote diodes, readout sequencer and external alarm source.
  Assumes the bench pulses go to start one conversion.
*/
`timescale 1ns/1ps
module temp_sensor_model
  import temp_readout_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench control
  input wire logic go,
  input wire logic lagTwo,
  input wire logic [1:0] openSet,
  input wire logic [1:0] shortSet,
  input wire logic [TEMP_W-1:0] tInt,
  input wire logic [TEMP_W-1:0] tD1,
  input wire logic [TEMP_W-1:0] tD2,
  input wire logic pullLow,
  // toward the block
  output logic convStart,
  output logic [NUM_CH-1:0] convValid,
  output logic [TEMP_W-1:0] rawInt,
  output logic [TEMP_W-1:0] rawD1,
  output logic [TEMP_W-1:0] rawD2,
  output logic [1:0] diodeHiPin,
  output logic [1:0] diodeLoPin,
  output logic extPullLow
);
  logic [2:0] step_r;
  assign diodeHiPin = openSet;
  assign diodeLoPin = shortSet;
  assign extPullLow = pullLow;
  // three readings; inverted outside valid so stale data never matches
  assign rawInt = convValid[0] ? tInt : ~tInt;
  assign rawD1 = convValid[1] ? tD1 : ~tD1;
  assign rawD2 = convValid[2] ? tD2 : ~tD2;
  // prompt answer lands in the check cycle and must be held pending
  always_ff @(posedge clk) begin
    if (rst) begin
      step_r <= 3'h0;
      convStart <= 1'b0;
      convValid <= 3'h0;
    end else begin
      convStart <= go;
      convValid <= (step_r != 3'h0 && step_r == {2'h0, lagTwo} + 3'h1) ? 3'h7 : 3'h0;
      step_r <= go ? 3'h1 : (step_r == 3'h0 || step_r > 3'h2) ? 3'h0 : step_r + 3'h1;
    end
  end
endmodule // temp_sensor_model

// [testbench.sv]
/*
  Testbench for temp_readout: APB tasks, conversions through the model.
  Assumes package, block, checker and model are compiled first.
*/
`timescale 1ns/1ps
module testbench
  import temp_readout_pkg::*;
;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, convStart, go, lagTwo, pullLow;
  logic dacOverdrivePin, serialBusStart, overtempAlarmLineIn, overtempAlarmLineOut;
  logic overtempAlarmLineOe, extPullLow, testMode, irq;
  logic [7:0] paddr, rawInt, rawD1, rawD2, tInt, tD1, tD2, dacCode;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] convValid;
  logic [1:0] openSet, shortSet, diodeHiPin, diodeLoPin;
  int errTotal, checksDone, cycles;
  // open-drain line with pull-up
  assign overtempAlarmLineIn = !((overtempAlarmLineOe && !overtempAlarmLineOut) || extPullLow);
  temp_readout i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .convStart, .convValid, .rawInt, .rawD1, .rawD2, .diodeHiPin,
    .diodeLoPin, .dacOverdrivePin, .serialBusStart, .overtempAlarmLineIn,
    .overtempAlarmLineOut, .overtempAlarmLineOe, .dacCode, .testMode, .irq);
  temp_sensor_model i_model (.clk, .rst, .go, .lagTwo, .openSet, .shortSet, .tInt, .tD1,
    .tD2, .pullLow, .convStart, .convValid, .rawInt, .rawD1, .rawD2, .diodeHiPin,
    .diodeLoPin, .extPullLow);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic completeRun();
    $display("checks %0d, mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      errTotal++;
      completeRun();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one transfer, held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    chk("ready", 32'h1, {31'h0, pready});
    chk("slave error", {31'h0, err}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 1'b0);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    apb(1'b0, a, APB_ZERO, 1'b0);
    chk(what, {24'h0, exp}, rd);
  endtask
  task automatic convert();
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    tick(8);
  endtask
  initial begin
    {rst, lagTwo} = 2'h3;
    {psel, penable, pwrite, go, pullLow, dacOverdrivePin, serialBusStart} = 7'h00;
    {paddr, pwdata, openSet, shortSet} = 44'h0;
    {tInt, tD1, tD2} = {8'h19, 8'h19, 8'hD8};
    tick(4);
    rst <= 1'b0;
    tick(1);
    chk("dac code", DAC_FULL_SCALE, dacCode);
    rdchk(ADDR_HIGH_INT, RST_HIGH, "high limit");
    rdchk(ADDR_LOW_EXT, RST_LOW, "low limit");
    rdchk(ADDR_HYST, RST_HYST, "hysteresis");
    rdchk(ADDR_DAC, DAC_FULL_SCALE, "dac setting");
    apb(1'b1, ADDR_TEMP_D1, 32'h0000_0055, 1'b1);
    rdchk(ADDR_TEMP_D1, 8'h00, "result after write");
    apb(1'b0, 8'h3C, APB_ZERO, 1'b1);
    wr(ADDR_HIGH_INT, 8'h10);
    wr(ADDR_LOW_EXT, 8'hE7);
    wr(ADDR_IRQ_EN, 8'hE1);
    convert();
    rdchk(ADDR_TEMP_D2, 8'hD8, "remote two");
    chk("irq", 32'h1, {31'h0, irq});
    rdchk(ADDR_STATUS2, 8'h21, "status");
    tick(2);
    chk("irq", 32'h0, {31'h0, irq});
    rdchk(ADDR_STATUS2, 8'h00, "status reread");
    {openSet, shortSet, lagTwo} <= 5'h0C;
    tick(4);
    convert();
    rdchk(ADDR_TEMP_D1, TEMP_OPEN_FAULT, "open diode");
    rdchk(ADDR_TEMP_D2, TEMP_SHORT_FAULT, "shorted diode");
    rdchk(ADDR_STATUS2, 8'h41, "fault status");
    {openSet, shortSet, lagTwo} <= 5'h01;
    tick(4);
    rdchk(ADDR_TEMP_D1, TEMP_OPEN_FAULT, "held result");
    wr(ADDR_IRQ_EN, 8'h00);
    convert();
    rdchk(ADDR_TEMP_D1, 8'h19, "recovered diode");
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_CLR, 8'hFF);
    rdchk(ADDR_STATUS2, 8'h00, "cleared status");
    wr(ADDR_HW_INT, 8'h10);
    convert();
    chk("alarm drive", 32'h1, {31'h0, overtempAlarmLineOe});
    chk("alarm level", 32'h0, {31'h0, overtempAlarmLineOut});
    tInt <= 8'h0E;
    convert();
    chk("alarm release", 32'h0, {31'h0, overtempAlarmLineOe});
    wr(ADDR_MODE, 8'h01);
    tick(2);
    chk("forced alarm", 32'h1, {31'h0, overtempAlarmLineOe});
    wr(ADDR_MODE, 8'h00);
    tick(4);
    wr(ADDR_DAC, 8'hFF);
    wr(ADDR_DAC, 8'h40);
    tick(2);
    chk("dac code", 32'h40, {24'h0, dacCode});
    pullLow <= 1'b1;
    tick(6);
    chk("forced dac", {24'h0, DAC_FULL_SCALE}, {24'h0, dacCode});
    rdchk(ADDR_DAC, 8'h40, "dac setting");
    pullLow <= 1'b0;
    tick(6);
    chk("restored dac", 32'h40, {24'h0, dacCode});
    dacOverdrivePin <= 1'b1;
    tick(6);
    chk("test mode", 32'h1, {31'h0, testMode});
    dacOverdrivePin <= 1'b0;
    tick(5);
    rdchk(ADDR_DAC, 8'h40, "dac in test");
    tick(2);
    chk("test exit", 32'h0, {31'h0, testMode});
    dacOverdrivePin <= 1'b1;
    tick(6);
    chk("test reentry", 32'h1, {31'h0, testMode});
    {dacOverdrivePin, serialBusStart} <= 2'h1;
    tick(6);
    serialBusStart <= 1'b0;
    chk("bus exit", 32'h0, {31'h0, testMode});
    completeRun();
  end
endmodule // testbench
